// >>> include/gpwas_pkg.sv
// package: register map, field positions and reset values for the shared gpio port
package gpwas_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PORT_DATA_LATCH = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIRECTION = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PULLUP_ENABLE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_INPUT_DISABLE = 4'h3;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_PORT_DATA_LATCH = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_DIRECTION = 8'h00;
  localparam logic [DATA_W-1:0] RST_PULLUP_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] RST_ANALOG_INPUT_DISABLE = 8'h00;

  // ----------------------------------------------------------------
  // pin field layout
  // ----------------------------------------------------------------
  localparam int unsigned PIN_LO = 2;
  localparam int unsigned PIN_HI = 7;
  // implemented bits of data, direction and pull-up registers
  localparam logic [DATA_W-1:0] PORT_BITS_MASK = 8'hfc;
  // implemented bits of the analog disable register
  localparam logic [DATA_W-1:0] AIDR_BITS_MASK = 8'h33;
  // analog disable bit position for pins seven, six, five, four
  localparam int unsigned AIDR_BIT_PIN7 = 5;
  localparam int unsigned AIDR_BIT_PIN6 = 4;
  localparam int unsigned AIDR_BIT_PIN5 = 1;
  localparam int unsigned AIDR_BIT_PIN4 = 0;
  // pins with an external interrupt input (a: 2, b: 3, c: 5)
  localparam logic [DATA_W-1:0] EXT_IRQ_PIN_MASK = 8'h2c;
  localparam int unsigned EXT_IRQ_A_PIN = 2;
  localparam int unsigned EXT_IRQ_B_PIN = 3;
  localparam int unsigned EXT_IRQ_C_PIN = 5;
  // comparator analog inputs
  localparam int unsigned COMP_POS_PIN = 7;
  localparam int unsigned COMP_NEG_PIN = 5;

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_SYNC_CLEAR = 2'h0;
  localparam logic [1:0] RST_SYNC_SHIFT_IN = 2'h1;

endpackage

// >>> hw/gpwas_port.sv
// six-pin general-purpose port with analog, comparator and interrupt sharing
//
// The plain strobed port and the register offsets are this design's own decisions.
module gpwas_port
  import gpwas_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_rmw_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [PIN_HI:PIN_LO] pin_in,
  output logic [PIN_HI:PIN_LO] pin_out,
  output logic [PIN_HI:PIN_LO] pin_oe_out,
  output logic [PIN_HI:PIN_LO] pullup_on_out,
  input wire logic [PIN_HI:PIN_LO] periph_oe_in,
  input wire logic [PIN_HI:PIN_LO] periph_data_in,
  input wire logic [PIN_HI:PIN_LO] ext_irq_en_in,
  input wire logic standby_mode_in,
  input wire logic standby_pin_hiz_in,
  input wire logic comparator_input_disable_in,
  output logic [PIN_HI:PIN_LO] periph_level_out,
  output logic ext_irq_in_a_out,
  output logic ext_irq_in_b_out,
  output logic ext_irq_in_c_out,
  output logic [PIN_HI:PIN_LO] analog_conn_out,
  output logic comparator_pos_in_out,
  output logic comparator_neg_in_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;

  // assertion is immediate, release waits two edges
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_r <= RST_SYNC_CLEAR;
    end else begin
      rst_sync_r <= {rst_sync_r[0], RST_SYNC_SHIFT_IN[0]};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  logic [PIN_HI:PIN_LO] pin_meta_r;
  logic [PIN_HI:PIN_LO] pin_sync_r;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] port_data_latch_r;
  logic [DATA_W-1:0] port_data_latch_nxt;
  logic [DATA_W-1:0] port_direction_r;
  logic [DATA_W-1:0] port_direction_nxt;
  logic [DATA_W-1:0] pullup_enable_r;
  logic [DATA_W-1:0] pullup_enable_nxt;
  logic [DATA_W-1:0] analog_input_disable_r;
  logic [DATA_W-1:0] analog_input_disable_nxt;

  always_comb begin
    port_data_latch_nxt = port_data_latch_r;
    port_direction_nxt = port_direction_r;
    pullup_enable_nxt = pullup_enable_r;
    analog_input_disable_nxt = analog_input_disable_r;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFS_PORT_DATA_LATCH: begin
          // stored regardless of direction
          port_data_latch_nxt = reg_wdata_in & PORT_BITS_MASK;
        end
        OFS_PORT_DIRECTION: begin
          port_direction_nxt = reg_wdata_in & PORT_BITS_MASK;
        end
        OFS_PULLUP_ENABLE: begin
          pullup_enable_nxt = reg_wdata_in & PORT_BITS_MASK;
        end
        OFS_ANALOG_INPUT_DISABLE: begin
          analog_input_disable_nxt = reg_wdata_in & AIDR_BITS_MASK;
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
  end

  // written value visible one edge after the strobe
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      port_data_latch_r <= RST_PORT_DATA_LATCH;
      port_direction_r <= RST_PORT_DIRECTION;
      pullup_enable_r <= RST_PULLUP_ENABLE;
      analog_input_disable_r <= RST_ANALOG_INPUT_DISABLE;
    end else begin
      port_data_latch_r <= port_data_latch_nxt;
      port_direction_r <= port_direction_nxt;
      pullup_enable_r <= pullup_enable_nxt;
      analog_input_disable_r <= analog_input_disable_nxt;
    end
  end

  // ----------------------------------------------------------------
  // per-pin analog sharing view
  // ----------------------------------------------------------------
  logic [PIN_HI:PIN_LO] dig_in_ok;

  // pins without an analog function always accept digital input
  always_comb begin
    dig_in_ok = '1;
    dig_in_ok[7] = analog_input_disable_r[AIDR_BIT_PIN7];
    dig_in_ok[6] = analog_input_disable_r[AIDR_BIT_PIN6];
    dig_in_ok[5] = analog_input_disable_r[AIDR_BIT_PIN5];
    dig_in_ok[4] = analog_input_disable_r[AIDR_BIT_PIN4];
  end

  // ----------------------------------------------------------------
  // pin drive, pull-up and input gating
  // ----------------------------------------------------------------
  logic hiz_lock;
  logic [PIN_HI:PIN_LO] pin_out_nxt;
  logic [PIN_HI:PIN_LO] pin_oe_nxt;
  logic [PIN_HI:PIN_LO] pullup_on_nxt;
  logic [PIN_HI:PIN_LO] in_blocked;
  logic [PIN_HI:PIN_LO] dig_level;
  logic [PIN_HI:PIN_LO] periph_level_nxt;
  logic [PIN_HI:PIN_LO] analog_conn_nxt;
  logic [PIN_HI:PIN_LO] pin_out_r;
  logic [PIN_HI:PIN_LO] pin_oe_r;
  logic [PIN_HI:PIN_LO] pullup_on_r;
  logic [PIN_HI:PIN_LO] periph_level_r;
  logic [PIN_HI:PIN_LO] analog_conn_r;

  // without the hiz bit, standby changes nothing
  assign hiz_lock = standby_mode_in & standby_pin_hiz_in;

  genvar gi;
  generate
    for (gi = PIN_LO; gi <= PIN_HI; gi++) begin : g_pin
      always_comb begin
        // peripheral wins over port output
        if (periph_oe_in[gi]) begin
          pin_out_nxt[gi] = periph_data_in[gi];
          pin_oe_nxt[gi] = 1'b1;
        end else begin
          pin_out_nxt[gi] = port_data_latch_r[gi];
          pin_oe_nxt[gi] = port_direction_r[gi];
        end
        // forced float in standby with the hiz bit set
        if (hiz_lock) begin
          pin_oe_nxt[gi] = 1'b0;
        end
        // drive low cuts the pull-up
        pullup_on_nxt[gi] = pullup_enable_r[gi] & ~(pin_oe_nxt[gi] & ~pin_out_nxt[gi]);
        // interrupt-enabled inputs stay live through standby
        in_blocked[gi] = hiz_lock & ~(EXT_IRQ_PIN_MASK[gi] & ext_irq_en_in[gi]);
        // analog pins with disable bit zero give no digital input
        dig_level[gi] = pin_sync_r[gi] & dig_in_ok[gi] & ~in_blocked[gi];
        periph_level_nxt[gi] = dig_level[gi];
        // analog path needs a floating input pin
        analog_conn_nxt[gi] = ~dig_in_ok[gi] & ~pin_oe_nxt[gi];
      end
    end
  endgenerate

  // registered outputs cost one cycle of pin latency
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      pullup_on_r <= '0;
      periph_level_r <= '0;
      analog_conn_r <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      pullup_on_r <= pullup_on_nxt;
      periph_level_r <= periph_level_nxt;
      analog_conn_r <= analog_conn_nxt;
    end
  end

  assign pin_out = pin_out_r;
  assign pin_oe_out = pin_oe_r;
  assign pullup_on_out = pullup_on_r;
  assign periph_level_out = periph_level_r;
  assign analog_conn_out = analog_conn_r;

  // ----------------------------------------------------------------
  // interrupt and comparator feeds
  // ----------------------------------------------------------------
  logic irq_a_r;
  logic irq_b_r;
  logic irq_c_r;
  logic irq_a_nxt;
  logic irq_b_nxt;
  logic irq_c_nxt;
  logic cmp_pos_r;
  logic cmp_neg_r;
  logic cmp_pos_nxt;
  logic cmp_neg_nxt;

  always_comb begin
    // software must mask the interrupt when the pin does other work
    irq_a_nxt = pin_sync_r[EXT_IRQ_A_PIN] & ~in_blocked[EXT_IRQ_A_PIN];
    irq_b_nxt = pin_sync_r[EXT_IRQ_B_PIN] & ~in_blocked[EXT_IRQ_B_PIN];
    irq_c_nxt = pin_sync_r[EXT_IRQ_C_PIN] & ~in_blocked[EXT_IRQ_C_PIN];
    // independent of latch and direction
    cmp_pos_nxt = ~comparator_input_disable_in;
    cmp_neg_nxt = ~comparator_input_disable_in;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
      irq_c_r <= 1'b0;
      cmp_pos_r <= 1'b0;
      cmp_neg_r <= 1'b0;
    end else begin
      irq_a_r <= irq_a_nxt;
      irq_b_r <= irq_b_nxt;
      irq_c_r <= irq_c_nxt;
      cmp_pos_r <= cmp_pos_nxt;
      cmp_neg_r <= cmp_neg_nxt;
    end
  end

  assign ext_irq_in_a_out = irq_a_r;
  assign ext_irq_in_b_out = irq_b_r;
  assign ext_irq_in_c_out = irq_c_r;
  assign comparator_pos_in_out = cmp_pos_r;
  assign comparator_neg_in_out = cmp_neg_r;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] port_read_view;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    port_read_view = '0;
    // rmw reads always see the latch
    if (reg_rmw_in) begin
      port_read_view = port_data_latch_r;
    end else begin
      for (int i = PIN_LO; i <= PIN_HI; i++) begin
        // gpio output reads latch, else the pin
        if (port_direction_r[i] && !periph_oe_in[i]) begin
          port_read_view[i] = port_data_latch_r[i];
        end else begin
          port_read_view[i] = dig_level[i];
        end
      end
    end
    rdata_nxt = RDATA_UNMAPPED;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_PORT_DATA_LATCH: begin
          rdata_nxt = port_read_view;
        end
        OFS_PORT_DIRECTION: begin
          rdata_nxt = port_direction_r;
        end
        OFS_PULLUP_ENABLE: begin
          rdata_nxt = pullup_enable_r;
        end
        OFS_ANALOG_INPUT_DISABLE: begin
          rdata_nxt = analog_input_disable_r;
        end
        default: begin
          rdata_nxt = RDATA_UNMAPPED;
        end
      endcase
    end
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= RDATA_UNMAPPED;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule

// >>> verif/gpwas_port_sva.sv
// assertion checker for the shared gpio port
module gpwas_port_sva
  import gpwas_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_rmw_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [PIN_HI:PIN_LO] pin_in,
  input wire logic [PIN_HI:PIN_LO] pin_out,
  input wire logic [PIN_HI:PIN_LO] pin_oe_out,
  input wire logic [PIN_HI:PIN_LO] pullup_on_out,
  input wire logic [PIN_HI:PIN_LO] periph_oe_in,
  input wire logic [PIN_HI:PIN_LO] periph_data_in,
  input wire logic [PIN_HI:PIN_LO] ext_irq_en_in,
  input wire logic standby_mode_in,
  input wire logic standby_pin_hiz_in,
  input wire logic comparator_input_disable_in,
  input wire logic ext_irq_in_a_out,
  input wire logic ext_irq_in_b_out,
  input wire logic comparator_pos_in_out,
  input wire logic comparator_neg_in_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] age_r;
  logic ok;
  logic lock;
  // outputs lag reset release by the sync stages, so wait them out
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  assign ok = (age_r == 3'h7);
  assign lock = standby_mode_in && standby_pin_hiz_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ------
  // assertions
  // ------
  AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  AST_RDATA_BITS: assert property ($past(reg_rd_in) |-> (reg_rdata_out & ~(($past(reg_addr_in)
    == OFS_ANALOG_INPUT_DISABLE) ? AIDR_BITS_MASK : PORT_BITS_MASK)) == 8'h00)
    else $error("unimplemented bit reads one");
  AST_HIZ: assert property (lock [*2] |-> pin_oe_out == 6'h00)
    else $error("pin driven in standby float");
  AST_PULLUP_LOW: assert property ((pullup_on_out & pin_oe_out & ~pin_out) == 6'h00)
    else $error("pull-up on a low driven pin");
  AST_PERIPH_DRIVE: assert property (ok && periph_oe_in[6] && !lock |=>
    pin_oe_out[6] && pin_out[6] == $past(periph_data_in[6]))
    else $error("peripheral does not drive pin");
  AST_IRQ_FEED: assert property ((ok && !lock) [*4] |->
    ext_irq_in_a_out == $past(pin_in[2], 3))
    else $error("interrupt feed not following pin");
  AST_IRQ_LOCK: assert property ((lock && !ext_irq_en_in[3]) [*4] |-> !ext_irq_in_b_out)
    else $error("locked input reaches interrupt");
  AST_CMP_EN: assert property ((ok && !comparator_input_disable_in) [*2] |->
    comparator_pos_in_out && comparator_neg_in_out)
    else $error("comparator input not enabled");
  AST_CMP_DIS: assert property (comparator_input_disable_in [*2] |->
    !comparator_pos_in_out && !comparator_neg_in_out)
    else $error("comparator input not disabled");
  COV_RMW: cover property (reg_rd_in && reg_rmw_in);
  COV_LOCK: cover property (lock [*4]);
  COV_PERIPH: cover property (periph_oe_in != 6'h00);
endmodule

bind gpwas_port gpwas_port_sva i_sva (.clk_in, .arst_n_in, .reg_addr_in, .reg_rd_in,
  .reg_rmw_in, .reg_rdata_out, .pin_in, .pin_out, .pin_oe_out, .pullup_on_out,
  .periph_oe_in, .periph_data_in, .ext_irq_en_in, .standby_mode_in, .standby_pin_hiz_in,
  .comparator_input_disable_in, .ext_irq_in_a_out, .ext_irq_in_b_out,
  .comparator_pos_in_out, .comparator_neg_in_out);

// >>> verif/gpwas_pin_model.sv
// far-side model: pin wires, external drivers and pull-ups
module gpwas_pin_model
  import gpwas_pkg::*;
(
  input wire logic clk_in,
  input wire logic [PIN_HI:PIN_LO] drv_in,
  input wire logic [PIN_HI:PIN_LO] oe_in,
  input wire logic [PIN_HI:PIN_LO] pu_in,
  input wire logic [PIN_HI:PIN_LO] ext_val_in,
  input wire logic [PIN_HI:PIN_LO] ext_oe_in,
  output logic [PIN_HI:PIN_LO] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PIN_HI:PIN_LO] float_r = 6'h15;
  // an open pin wanders every cycle so a stale value cannot pass
  always_ff @(posedge clk_in) begin
    float_r <= ~float_r;
  end
  assign level_out = (oe_in & drv_in) | (~oe_in & ext_oe_in & ext_val_in)
    | (~oe_in & ~ext_oe_in & (pu_in | float_r));
endmodule

// >>> verif/gpwas_port_bench.sv
// self-checking bench for the shared gpio port
module gpwas_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpwas_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rmw = 1'b0;
  logic [5:0] poe = 6'h00;
  logic [5:0] pdata = 6'h00;
  logic [5:0] irq_en = 6'h00;
  logic stby = 1'b0;
  logic hiz = 1'b0;
  logic cdis = 1'b0;
  logic [5:0] ext_val = 6'h16;
  logic [5:0] ext_oe = 6'h00;
  logic [7:0] rdata;
  logic [5:0] p_out;
  logic [5:0] p_oe;
  logic [5:0] p_pu;
  logic [5:0] p_lvl;
  logic [5:0] plvl;
  logic [5:0] ana;
  logic irq_a;
  logic irq_b;
  logic irq_c;
  logic cmp_p;
  logic cmp_n;
  int fail_count = 0;
  int total_checks = 0;

  gpwas_port i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rmw_in(rmw),
    .reg_rdata_out(rdata), .pin_in(p_lvl), .pin_out(p_out), .pin_oe_out(p_oe),
    .pullup_on_out(p_pu), .periph_oe_in(poe), .periph_data_in(pdata),
    .ext_irq_en_in(irq_en), .standby_mode_in(stby), .standby_pin_hiz_in(hiz),
    .comparator_input_disable_in(cdis), .periph_level_out(plvl),
    .ext_irq_in_a_out(irq_a), .ext_irq_in_b_out(irq_b), .ext_irq_in_c_out(irq_c),
    .analog_conn_out(ana), .comparator_pos_in_out(cmp_p), .comparator_neg_in_out(cmp_n));
  gpwas_pin_model i_pins (.clk_in(clk_in), .drv_in(p_out), .oe_in(p_oe), .pu_in(p_pu),
    .ext_val_in(ext_val), .ext_oe_in(ext_oe), .level_out(p_lvl));

  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // ------
  // bus and compare helpers
  // ------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic m, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    rmw <= m;
    @(posedge clk_in);
    rd <= 1'b0;
    rmw <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset();
    rd_chk(OFS_PORT_DATA_LATCH, 1'b1, 8'h00);
    rd_chk(OFS_PORT_DIRECTION, 1'b0, 8'h00);
    rd_chk(OFS_ANALOG_INPUT_DISABLE, 1'b0, 8'h00);
    rd_chk(OFS_PULLUP_ENABLE, 1'b0, 8'h00);
    check({2'h0, ana}, 8'h3c);
    wr_reg(4'hf, 8'hff);
    rd_chk(4'hf, 1'b0, RDATA_UNMAPPED);
  endtask
  task automatic t_out();
    wr_reg(OFS_PULLUP_ENABLE, 8'hff);
    wr_reg(OFS_PORT_DATA_LATCH, 8'ha7);
    wr_reg(OFS_PORT_DIRECTION, 8'hff);
    rd_chk(OFS_PULLUP_ENABLE, 1'b0, 8'hfc);
    check({2'h0, p_oe}, 8'h3f);
    check({2'h0, p_out}, 8'h29);
    check({2'h0, p_pu}, 8'h29);
    rd_chk(OFS_PORT_DATA_LATCH, 1'b0, 8'ha4);
  endtask
  task automatic t_in();
    @(posedge clk_in);
    ext_oe <= 6'h3f;
    wr_reg(OFS_PORT_DIRECTION, 8'h00);
    wr_reg(OFS_ANALOG_INPUT_DISABLE, 8'hff);
    wr_reg(OFS_PORT_DATA_LATCH, 8'hfc);
    settle(4);
    check({2'h0, p_oe}, 8'h00);
    check({2'h0, plvl}, 8'h16);
    rd_chk(OFS_ANALOG_INPUT_DISABLE, 1'b0, 8'h33);
    rd_chk(OFS_PORT_DATA_LATCH, 1'b0, 8'h58);
    rd_chk(OFS_PORT_DATA_LATCH, 1'b1, 8'hfc);
    // pull-up switched off first; the analog path does not depend on it
    wr_reg(OFS_PULLUP_ENABLE, 8'h00);
    wr_reg(OFS_ANALOG_INPUT_DISABLE, 8'h22);
    settle(4);
    check({2'h0, ana}, 8'h14);
    check({2'h0, p_pu}, 8'h00);
    rd_chk(OFS_PORT_DATA_LATCH, 1'b0, 8'h08);
  endtask
  task automatic t_periph();
    wr_reg(OFS_ANALOG_INPUT_DISABLE, 8'hff);
    poe <= 6'h12;
    pdata <= 6'h02;
    settle(4);
    check({2'h0, p_oe}, 8'h12);
    rd_chk(OFS_PORT_DATA_LATCH, 1'b0, 8'h18);
    rd_chk(OFS_PORT_DATA_LATCH, 1'b1, 8'hfc);
  endtask
  task automatic t_standby();
    wr_reg(OFS_PORT_DIRECTION, 8'hfc);
    poe <= 6'h00;
    ext_val <= 6'h1f;
    irq_en <= 6'h09;
    stby <= 1'b1;
    hiz <= 1'b1;
    settle(5);
    check({2'h0, p_oe}, 8'h00);
    check({2'h0, plvl}, 8'h09);
    check({7'h0, irq_a}, 8'h01);
    check({7'h0, irq_c}, 8'h01);
    check({7'h0, irq_b}, 8'h00);
    @(posedge clk_in);
    hiz <= 1'b0;
    settle(2);
    check({p_oe, p_out[2], p_out[3]}, 8'hff);
    @(posedge clk_in);
    stby <= 1'b0;
    cdis <= 1'b1;
    settle(3);
    check({6'h0, cmp_p, cmp_n}, 8'h00);
    // analog disable bits cleared first; the comparator feeds follow cdis alone
    wr_reg(OFS_ANALOG_INPUT_DISABLE, 8'h00);
    cdis <= 1'b0;
    settle(3);
    check({6'h0, cmp_p, cmp_n}, 8'h03);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_out();
    t_in();
    t_periph();
    t_standby();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    print_verdict();
  end
endmodule
